// ### verilog/rsp_cfg.svh
`ifndef RSP_CFG_SVH
`define RSP_CFG_SVH

// ======================================================
// timing
`define RSP_CLK_NS        8
`define RSP_TICK_NS       1000
`define RSP_TICK_CYC      (`RSP_TICK_NS / `RSP_CLK_NS)

// ======================================================
// register byte offsets
`define RSP_OFF_CTRL      12'h000
`define RSP_OFF_CONFIG    12'h004
`define RSP_OFF_READY_SP  12'h008
`define RSP_OFF_ALM_TIME  12'h00C
`define RSP_OFF_STATUS    12'h010
`define RSP_OFF_SETPOINT  12'h014
`define RSP_OFF_ELAPSED   12'h018
`define RSP_OFF_SEG_BASE  12'h100
`define RSP_SEG_AREA_HI   11
`define RSP_SEG_AREA_LO   8
`define RSP_SEG_IDX_HI    6
`define RSP_SEG_IDX_LO    3
`define RSP_SEG_WORD_BIT  2
`define RSP_SEG_PAD_BIT   7

// ======================================================
// command bits (write one to act)
`define RSP_CMD_ASSIGN    0
`define RSP_CMD_RUN       1
`define RSP_CMD_HOLD      2
`define RSP_CMD_RESUME    3
`define RSP_CMD_RESET     4
`define RSP_CMD_ACK       5
`define RSP_CMD_UNASSIGN  6
`define RSP_CMD_TRIG_CLR  7

// ======================================================
// config fields
`define RSP_CFG_CYC_HI    6
`define RSP_CFG_CYC_LO    0
`define RSP_CFG_MEM       7
`define RSP_CFG_EVT_HI    15
`define RSP_CFG_EVT_LO    8
`define RSP_CFG_TLAT_HI   17
`define RSP_CFG_TLAT_LO   16

// ======================================================
// segment words
`define RSP_SEG_SP_HI     15
`define RSP_SEG_SP_LO     0
`define RSP_SEG_TOL_HI    23
`define RSP_SEG_TOL_LO    16
`define RSP_SEG_TOL_EN    24
`define RSP_SEG_TRG_HI    26
`define RSP_SEG_TRG_LO    25
`define RSP_SEG_LAST      27
`define RSP_SEG_DUR_HI    15
`define RSP_SEG_DUR_LO    0
`define RSP_SEG_EVT_HI    23
`define RSP_SEG_EVT_LO    16
`define RSP_TOL_MAX       8'd99

// ======================================================
// status fields
`define RSP_ST_MODE_HI    2
`define RSP_ST_MODE_LO    0
`define RSP_ST_SEG_HI     7
`define RSP_ST_SEG_LO     4
`define RSP_ST_ASSIGNED   8
`define RSP_ST_ALARM      9
`define RSP_ST_CYC_HI     22
`define RSP_ST_CYC_LO     16

// ======================================================
// reset values and misc constants
`define RSP_READY_SEG     4'h0
`define RSP_FIRST_SEG     4'h1
`define RSP_LAST_IDX      4'hF
`define RSP_CYC_ENDLESS   7'h00
`define RSP_RST_CONFIG    18'h00001
`define RSP_RST_ALM_TIME  16'h000A
`define RSP_TRG_NONE      2'h0
`define RSP_TRG_A         2'h1
`define RSP_TRG_B         2'h2

`endif

// ### verilog/rsp_pkg.sv
package rsp_pkg;

   typedef enum logic [2:0] {
      RSP_START    = 3'b000,
      RSP_RUN      = 3'b001,
      RSP_HOLD     = 3'b010,
      RSP_TOL_HOLD = 3'b011,
      RSP_WAIT     = 3'b100
   } rsp_mode_e;

   typedef struct packed {
      rsp_mode_e    mode;
      logic [3:0]   seg;
      logic         assigned;
      logic [15:0]  elapsed;
      logic [15:0]  dur;
      logic [15:0]  sp;
      logic [7:0]   tol;
      logic         tol_en;
      logic [1:0]   trig_sel;
      logic         last;
      logic [7:0]   events;
      logic [6:0]   cyc_cnt;
      logic [6:0]   tick_cnt;
      logic         tick;
      logic [1:0]   trig_latch;
      logic [17:0]  config_r;
      logic [15:0]  ready_sp;
      logic [15:0]  alm_time;
      logic         ack;
      logic         alarm_out;
      logic [31:0]  prdata;
      logic         pready;
      logic         pslverr;
   } rsp_state_s;

   typedef struct packed {
      logic [15:0]  cnt;
      logic         flag;
   } rsp_alm_s;

endpackage : rsp_pkg

// ### verilog/rsp_alarm_if.sv
interface rsp_alarm_if;
   logic         active;
   logic         ack;
   logic         tick;
   logic [15:0]  limit;
   logic         alarm;

   modport seq (output active, output ack, output tick, output limit, input alarm);
   modport alm (input active, input ack, input tick, input limit, output alarm);
endinterface : rsp_alarm_if

// ### verilog/rsp_alarm_timer.sv
`include "rsp_cfg.svh"

module rsp_alarm_timer (
   input  wire logic  clk,
   input  wire logic  ce,
   input  wire logic  rst_n,
   rsp_alarm_if.alm   alm
);

   rsp_pkg::rsp_alm_s  st_q;
   rsp_pkg::rsp_alm_s  st_d;

   always_comb begin
      st_d = st_q;
      if (alm.ack) begin
         st_d.cnt  = '0;
         st_d.flag = 1'b0;
      end else if (!alm.active) begin
         st_d.cnt = '0;
      end else if (st_q.cnt >= alm.limit) begin
         st_d.flag = 1'b1;
      end else if (alm.tick) begin
         st_d.cnt = st_q.cnt + 16'h0001;
      end
   end

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         st_q <= '0;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   assign alm.alarm = st_q.flag;

endmodule : rsp_alarm_timer

// ### verilog/rsp_sequencer.sv
`include "rsp_cfg.svh"

module rsp_sequencer (
   input  wire logic         clk,
   input  wire logic         rst_n,
   input  wire logic         ce,
   input  wire logic         psel,
   input  wire logic         penable,
   input  wire logic         pwrite,
   input  wire logic [11:0]  paddr,
   input  wire logic [31:0]  pwdata,
   output logic [31:0]       prdata,
   output logic              pready,
   output logic              pslverr,
   input  wire logic [15:0]  pv,
   input  wire logic [1:0]   trig_in,
   input  wire logic         pwr_restore,
   output logic [15:0]       setpoint_out,
   output logic [7:0]        event_out,
   output logic              alarm_out
);

   // ======================================================
   // reset release
   logic        rst_m_q;
   logic        rst_s_q;

   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rst_m_q <= 1'b0;
         rst_s_q <= 1'b0;
      end else begin
         rst_m_q <= 1'b1;
         rst_s_q <= rst_m_q;
      end
   end

   // ======================================================
   // helpers
   function automatic logic out_of_band(input logic [15:0] pv_i, input logic [15:0] sp_i,
                                        input logic [7:0] tol_i, input logic en_i);
      logic signed [17:0] lim;
      logic [7:0]         mag;
      lim = $signed({2'b00, sp_i}) + 18'($signed(tol_i));
      mag = tol_i[7] ? 8'(-tol_i) : tol_i;
      if (!en_i || mag > `RSP_TOL_MAX) begin
         return 1'b0;
      end else if (!tol_i[7]) begin
         return $signed({2'b00, pv_i}) > lim;
      end else begin
         return $signed({2'b00, pv_i}) < lim;
      end
   endfunction : out_of_band

   function automatic logic trig_met(input logic [1:0] sel, input logic [1:0] lvl,
                                     input logic [1:0] latch, input logic [1:0] lat_cfg);
      logic [1:0] v;
      v[0] = lat_cfg[0] ? latch[0] : lvl[0];
      v[1] = lat_cfg[1] ? latch[1] : lvl[1];
      unique case (sel)
         `RSP_TRG_NONE: return 1'b1;
         `RSP_TRG_A:    return v[0];
         `RSP_TRG_B:    return v[1];
         default: begin
            if (lat_cfg[0] != lat_cfg[1]) begin
               return lat_cfg[0] ? v[1] : v[0];
            end else begin
               return v[0] | v[1];
            end
         end
      endcase
   endfunction : trig_met

   // ======================================================
   // segment storage, index 0 is the ready segment
   logic [31:0]  seg_w0 [16];
   logic [31:0]  seg_w1 [16];

   rsp_pkg::rsp_state_s  st_q;
   rsp_pkg::rsp_state_s  st_d;

   logic          apb_wr;
   logic          apb_setup;
   logic          seg_area;
   logic [3:0]    seg_idx;
   logic [3:0]    ent_idx;
   logic [31:0]   ent_w0;
   logic [31:0]   ent_w1;
   logic          oob;
   localparam logic [11:0] SEG_BASE = `RSP_OFF_SEG_BASE;

   rsp_alarm_if   alm_if ();

   assign apb_setup = psel && !penable;
   assign apb_wr    = psel && penable && pwrite && st_q.pready;
   assign seg_area  = paddr[`RSP_SEG_AREA_HI:`RSP_SEG_AREA_LO] ==
                      SEG_BASE[`RSP_SEG_AREA_HI:`RSP_SEG_AREA_LO] && !paddr[`RSP_SEG_PAD_BIT];
   assign seg_idx   = paddr[`RSP_SEG_IDX_HI:`RSP_SEG_IDX_LO];
   assign oob       = out_of_band(pv, st_q.sp, st_q.tol, st_q.tol_en);

   // edits land in storage only; a running segment keeps its loaded copy
   always_ff @(posedge clk) begin
      if (ce && apb_wr && seg_area) begin
         if (paddr[`RSP_SEG_WORD_BIT]) begin
            seg_w1[seg_idx] <= pwdata;
         end else begin
            seg_w0[seg_idx] <= pwdata;
         end
      end
   end

   assign ent_w0 = seg_w0[ent_idx];
   assign ent_w1 = seg_w1[ent_idx];

   // ======================================================
   // next state
   always_comb begin
      logic        do_enter;
      logic        to_ready;
      logic [31:0] cmd;
      do_enter = 1'b0;
      to_ready = 1'b0;
      cmd      = '0;
      ent_idx  = st_q.seg;
      st_d     = st_q;
      st_d.ack = 1'b0;

      // tick prescaler
      st_d.tick = 1'b0;
      if (st_q.tick_cnt == 7'(`RSP_TICK_CYC - 1)) begin
         st_d.tick_cnt = '0;
         st_d.tick     = 1'b1;
      end else begin
         st_d.tick_cnt = st_q.tick_cnt + 7'h01;
      end

      // bus slave: answer prepared in setup, zero wait state
      st_d.pready = 1'b0;
      if (apb_setup) begin
         st_d.pready  = 1'b1;
         st_d.pslverr = 1'b0;
         st_d.prdata  = '0;
         if (seg_area) begin
            st_d.prdata = paddr[`RSP_SEG_WORD_BIT] ? seg_w1[seg_idx] : seg_w0[seg_idx];
         end else begin
            unique case (paddr)
               `RSP_OFF_CTRL:     st_d.prdata = '0;
               `RSP_OFF_CONFIG:   st_d.prdata = 32'(st_q.config_r);
               `RSP_OFF_READY_SP: st_d.prdata = 32'(st_q.ready_sp);
               `RSP_OFF_ALM_TIME: st_d.prdata = 32'(st_q.alm_time);
               `RSP_OFF_STATUS: begin
                  st_d.prdata[`RSP_ST_MODE_HI:`RSP_ST_MODE_LO] = st_q.mode;
                  st_d.prdata[`RSP_ST_SEG_HI:`RSP_ST_SEG_LO]   = st_q.seg;
                  st_d.prdata[`RSP_ST_ASSIGNED]                = st_q.assigned;
                  st_d.prdata[`RSP_ST_ALARM]                   = alm_if.alarm;
                  st_d.prdata[`RSP_ST_CYC_HI:`RSP_ST_CYC_LO]   = st_q.cyc_cnt;
               end
               `RSP_OFF_SETPOINT: st_d.prdata = 32'(st_q.sp);
               `RSP_OFF_ELAPSED:  st_d.prdata = 32'(st_q.elapsed);
               default:           st_d.pslverr = 1'b1;
            endcase
         end
      end
      if (apb_wr && !seg_area) begin
         unique case (paddr)
            `RSP_OFF_CTRL:     cmd = pwdata;
            `RSP_OFF_CONFIG:   st_d.config_r = pwdata[17:0];
            `RSP_OFF_READY_SP: st_d.ready_sp = pwdata[15:0];
            `RSP_OFF_ALM_TIME: st_d.alm_time = pwdata[15:0];
            default: ;
         endcase
      end

      // trigger latches: set wins over a clear in the same cycle
      if (cmd[`RSP_CMD_TRIG_CLR]) begin
         st_d.trig_latch = '0;
      end
      st_d.trig_latch = st_d.trig_latch | trig_in;
      st_d.ack = cmd[`RSP_CMD_ACK];
      st_d.alarm_out = alm_if.alarm && !st_q.ack;

      // operator commands, reset, ack and trigger clear from any mode, each other only from its one legal mode
      if (cmd[`RSP_CMD_RESET]) begin
         to_ready = 1'b1;
      end else if ((cmd[`RSP_CMD_ASSIGN] || cmd[`RSP_CMD_UNASSIGN]) &&
                   st_q.mode == rsp_pkg::RSP_START && st_q.seg == `RSP_READY_SEG) begin
         st_d.assigned = cmd[`RSP_CMD_ASSIGN];
         to_ready      = 1'b1;
      end else if (cmd[`RSP_CMD_RUN]) begin
         if (st_q.mode == rsp_pkg::RSP_START && st_q.seg == `RSP_READY_SEG &&
             st_q.assigned) begin
            st_d.cyc_cnt = '0;
            ent_idx      = `RSP_FIRST_SEG;
            do_enter     = 1'b1;
         end
      end else if (cmd[`RSP_CMD_HOLD]) begin
         if (st_q.mode == rsp_pkg::RSP_RUN) begin
            st_d.mode = rsp_pkg::RSP_HOLD;
         end
      end else if (cmd[`RSP_CMD_RESUME]) begin
         if (st_q.mode == rsp_pkg::RSP_HOLD) begin
            st_d.mode = rsp_pkg::RSP_RUN;
         end
      end else if (pwr_restore) begin
         if (st_q.mode != rsp_pkg::RSP_START) begin
            if (st_q.config_r[`RSP_CFG_MEM]) begin
               st_d.mode = rsp_pkg::RSP_RUN;
            end else begin
               to_ready = 1'b1;
            end
         end
      end else begin
         // profile sequencing; hold leaves every field untouched
         unique case (st_q.mode)
            rsp_pkg::RSP_START: ;
            rsp_pkg::RSP_HOLD:  ;
            rsp_pkg::RSP_WAIT: begin
               if (trig_met(st_q.trig_sel, trig_in, st_q.trig_latch,
                            st_q.config_r[`RSP_CFG_TLAT_HI:`RSP_CFG_TLAT_LO])) begin
                  st_d.mode = rsp_pkg::RSP_RUN;
               end
            end
            rsp_pkg::RSP_TOL_HOLD: begin
               if (!oob) begin
                  st_d.mode = rsp_pkg::RSP_RUN;
               end
            end
            rsp_pkg::RSP_RUN: begin
               if (oob) begin
                  st_d.mode = rsp_pkg::RSP_TOL_HOLD;
               end else if (st_q.elapsed >= st_q.dur) begin
                  if (st_q.last || st_q.seg == `RSP_LAST_IDX) begin
                     st_d.cyc_cnt = st_q.cyc_cnt + 7'h01;
                     if (st_q.config_r[`RSP_CFG_CYC_HI:`RSP_CFG_CYC_LO] != `RSP_CYC_ENDLESS &&
                         st_d.cyc_cnt >= st_q.config_r[`RSP_CFG_CYC_HI:`RSP_CFG_CYC_LO]) begin
                        to_ready = 1'b1;
                     end else begin
                        ent_idx  = `RSP_FIRST_SEG;
                        do_enter = 1'b1;
                     end
                  end else begin
                     ent_idx  = st_q.seg + 4'h1;
                     do_enter = 1'b1;
                  end
               end else if (st_q.tick) begin
                  st_d.elapsed = st_q.elapsed + 16'h0001;
               end
            end
            default: to_ready = 1'b1;
         endcase
      end

      if (to_ready) begin
         st_d.mode     = rsp_pkg::RSP_START;
         st_d.seg      = `RSP_READY_SEG;
         st_d.elapsed  = '0;
         st_d.sp       = st_q.ready_sp;
         st_d.events   = st_q.config_r[`RSP_CFG_EVT_HI:`RSP_CFG_EVT_LO];
         st_d.tol_en   = 1'b0;
         st_d.trig_sel = `RSP_TRG_NONE;
      end else if (do_enter) begin
         // fields copied now so later edits of this segment are not seen
         st_d.seg      = ent_idx;
         st_d.elapsed  = '0;
         st_d.sp       = ent_w0[`RSP_SEG_SP_HI:`RSP_SEG_SP_LO];
         st_d.tol      = ent_w0[`RSP_SEG_TOL_HI:`RSP_SEG_TOL_LO];
         st_d.tol_en   = ent_w0[`RSP_SEG_TOL_EN];
         st_d.trig_sel = ent_w0[`RSP_SEG_TRG_HI:`RSP_SEG_TRG_LO];
         st_d.last     = ent_w0[`RSP_SEG_LAST];
         st_d.dur      = ent_w1[`RSP_SEG_DUR_HI:`RSP_SEG_DUR_LO];
         st_d.events   = ent_w1[`RSP_SEG_EVT_HI:`RSP_SEG_EVT_LO];
         st_d.mode     = (ent_w0[`RSP_SEG_TRG_HI:`RSP_SEG_TRG_LO] == `RSP_TRG_NONE) ?
                         rsp_pkg::RSP_RUN : rsp_pkg::RSP_WAIT;
      end
   end

   // ======================================================
   // state register
   always_ff @(posedge clk or negedge rst_s_q) begin
      if (!rst_s_q) begin
         st_q          <= '0;
         st_q.mode     <= rsp_pkg::RSP_START;
         st_q.seg      <= `RSP_READY_SEG;
         st_q.config_r <= `RSP_RST_CONFIG;
         st_q.alm_time <= `RSP_RST_ALM_TIME;
      end else if (ce) begin
         st_q <= st_d;
      end
   end

   // ======================================================
   // tolerance alarm timer
   assign alm_if.active = (st_q.mode == rsp_pkg::RSP_TOL_HOLD);
   assign alm_if.ack    = st_q.ack;
   assign alm_if.tick   = st_q.tick;
   assign alm_if.limit  = st_q.alm_time;

   rsp_alarm_timer u_alarm (
      .clk   (clk),
      .ce    (ce),
      .rst_n (rst_s_q),
      .alm   (alm_if.alm)
   );

   assign prdata       = st_q.prdata;
   assign pready       = st_q.pready;
   assign pslverr      = st_q.pslverr;
   assign setpoint_out = st_q.sp;
   assign event_out    = st_q.events;
   assign alarm_out    = st_q.alarm_out;

endmodule : rsp_sequencer

// ### verification/rsp_env_model.sv
module rsp_env_model (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic [15:0] pv_goal,
   input  wire logic [1:0]  trig_goal,
   output logic      [15:0] pv,
   output logic      [1:0]  trig_in
);
   timeunit 1ns;
   timeprecision 1ps;
   // ==========
   // sensor and trigger lines lag the operator by one clock
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         pv      <= 16'h0000;
         trig_in <= 2'h0;
      end else begin
         pv      <= pv_goal;
         trig_in <= trig_goal;
      end
   end
endmodule : rsp_env_model

// ### verification/rsp_seq_chk.sv
module rsp_seq_chk (
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        ce,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        pready,
   input wire logic        pslverr,
   input wire logic [15:0] pv,
   input wire logic [1:0]  trig_in,
   input wire logic        pwr_restore,
   input wire logic [15:0] setpoint_out,
   input wire logic [7:0]  event_out,
   input wire logic        alarm_out
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!rst_n);
   // ==========
   // shadows of the writes the checks rely on
   logic        acc;
   logic        ctl;
   logic [15:0] rsp_q;
   logic [7:0]  rev_q;
   logic [15:0] atm_q;
   logic [23:0] age_q;
   logic        frz_q;
   assign acc = psel && penable && pwrite && pready;
   assign ctl = acc && paddr == 12'h000;
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rsp_q <= 16'h0000;
         rev_q <= 8'h00;
         atm_q <= 16'h000A;
         age_q <= 24'h000000;
         frz_q <= 1'b0;
      end else if (ce) begin
         if (acc && paddr == 12'h008) rsp_q <= pwdata[15:0];
         if (acc && paddr == 12'h004) rev_q <= pwdata[15:8];
         if (acc && paddr == 12'h00C) atm_q <= pwdata[15:0];
         // saturates so a long quiet spell never wraps to a small age
         age_q <= (ctl && pwdata[5]) ? 24'h000000 : age_q + {23'h000000, ~&age_q};
         if (ctl || pwr_restore) frz_q <= ctl && pwdata[7:0] == 8'h04;
      end
   end
   // ==========
   // assertions
   property p_answer; psel && !penable |=> pready; endproperty
   a_answer: assert property (p_answer) else $error("no answer after setup");
   property p_rdy_acc; pready |-> psel && penable; endproperty
   a_rdy_acc: assert property (p_rdy_acc) else $error("ready outside access phase");
   property p_err_hole; psel && penable && paddr inside {[12'h01C:12'h0FC]} |-> pslverr; endproperty
   a_err_hole: assert property (p_err_hole) else $error("unmapped access not refused");
   property p_err_map; psel && penable && paddr <= 12'h018 |-> !pslverr; endproperty
   a_err_map: assert property (p_err_map) else $error("mapped access refused");
   property p_ack; ctl && pwdata[5] |-> ##[1:2] !alarm_out; endproperty
   a_ack: assert property (p_ack) else $error("alarm stays after acknowledge");
   property p_rst_ready; ctl && pwdata[4] |-> ##[1:2] (setpoint_out == rsp_q && event_out == rev_q); endproperty
   a_rst_ready: assert property (p_rst_ready) else $error("reset left outputs off ready");
   property p_frozen;
      frz_q && !(psel && pwrite && paddr == 12'h000) && !pwr_restore |=> $stable(setpoint_out) && $stable(event_out);
   endproperty
   a_frozen: assert property (p_frozen) else $error("outputs moved in hold");
   property p_not_early; $rose(alarm_out) |-> age_q + 24'd250 >= atm_q * 24'd125; endproperty
   a_not_early: assert property (p_not_early) else $error("alarm earlier than alarm time");
   c_alarm: cover property ($rose(alarm_out));
   c_ack: cover property (ctl && pwdata[5] && alarm_out);
   c_hold: cover property (frz_q [*8]);
endmodule : rsp_seq_chk

bind rsp_sequencer rsp_seq_chk u_chk (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable),
   .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
   .pv(pv), .trig_in(trig_in), .pwr_restore(pwr_restore), .setpoint_out(setpoint_out),
   .event_out(event_out), .alarm_out(alarm_out));

// ### verification/tb_ramp_soak_profile_sequencer.sv
module tb_ramp_soak_profile_sequencer;
   timeunit 1ns;
   timeprecision 1ps;
   logic        clk, rst_n, ce, psel, penable, pwrite, pwr_restore, pready, pslverr, alarm_out, er;
   logic [11:0] paddr;
   logic [31:0] pwdata, prdata, r;
   logic [15:0] pv, pv_goal, setpoint_out, e;
   logic [1:0]  trig_in, trig_goal;
   logic [7:0]  event_out;
   int          errors, comparisons, n;

   rsp_sequencer dut (.clk(clk), .rst_n(rst_n), .ce(ce), .psel(psel), .penable(penable), .pwrite(pwrite),
      .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .pv(pv),
      .trig_in(trig_in), .pwr_restore(pwr_restore), .setpoint_out(setpoint_out), .event_out(event_out),
      .alarm_out(alarm_out));
   rsp_env_model u_env (.clk(clk), .rst_n(rst_n), .pv_goal(pv_goal), .trig_goal(trig_goal), .pv(pv),
      .trig_in(trig_in));

   initial begin
      clk = 1'b0;
      forever #4 clk = ~clk;
   end
   // ==========
   // bus and check tasks
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
      int k;
      k = 0;
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= wr;
      paddr <= a;
      pwdata <= d;
      @(posedge clk);
      penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 16) begin
         k++;
         @(posedge clk);
      end
      if (k == 16) chk(32'h0, 32'h1);
      r = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask : apb
   task automatic cmd(input logic [7:0] b);
      apb(1'b1, 12'h000, {24'h000000, b});
   endtask : cmd
   task automatic st(input logic [2:0] m, input logic [3:0] s);
      int k;
      k = 0;
      apb(1'b0, 12'h010, 32'h0);
      // polls so a slow mode change is not mistaken for a wrong one
      while ((r & 32'hF7) !== {24'h0, s, 1'b0, m} && k < 300) begin
         k++;
         apb(1'b0, 12'h010, 32'h0);
      end
      chk(r & 32'hF7, {24'h0, s, 1'b0, m});
   endtask : st
   task automatic wait_alarm;
      n = 0;
      while (alarm_out !== 1'b1 && n < 3000) begin
         n++;
         @(posedge clk);
      end
   endtask : wait_alarm
   task automatic pwr_pulse;
      pwr_restore <= 1'b1;
      @(posedge clk);
      pwr_restore <= 1'b0;
   endtask : pwr_pulse
   task automatic print_verdict;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask : print_verdict

   initial begin
      repeat (40000) @(posedge clk);
      chk(32'h0, 32'h1);
      print_verdict();
   end
   // ==========
   // tests
   initial begin
      {rst_n, psel, penable, pwrite, pwr_restore, paddr, pwdata, pv_goal, trig_goal} = '0;
      ce = 1'b1;
      errors = 0;
      comparisons = 0;
      repeat (3) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      apb(1'b0, 12'h004, 32'h0);
      chk(r, 32'h00000001);
      apb(1'b0, 12'h00C, 32'h0);
      chk(r, 32'h0000000A);
      st(rsp_pkg::RSP_START, 4'h0);
      apb(1'b0, 12'h020, 32'h0);
      chk({r[30:0], er}, 32'h1);
      $display("test reset_values done");
      apb(1'b1, 12'h004, 32'h00005A01);
      apb(1'b1, 12'h008, 32'h00000050);
      apb(1'b1, 12'h108, 32'h010A0100);
      apb(1'b1, 12'h10C, 32'h00110003);
      apb(1'b1, 12'h110, 32'h08000200);
      apb(1'b1, 12'h114, 32'h00220002);
      pv_goal <= 16'h0100;
      cmd(8'h01);
      cmd(8'h04);
      cmd(8'h08);
      st(rsp_pkg::RSP_START, 4'h0);
      chk({31'h0, r[8]}, 32'h1);
      cmd(8'h02);
      st(rsp_pkg::RSP_RUN, 4'h1);
      chk({16'h0, setpoint_out}, 32'h0100);
      chk({24'h0, event_out}, 32'h11);
      apb(1'b1, 12'h110, 32'h08000300);
      cmd(8'h04);
      st(rsp_pkg::RSP_HOLD, 4'h1);
      apb(1'b0, 12'h018, 32'h0);
      e = r[15:0];
      repeat (400) @(posedge clk);
      apb(1'b0, 12'h018, 32'h0);
      chk(r, {16'h0, e});
      cmd(8'h08);
      st(rsp_pkg::RSP_RUN, 4'h1);
      st(rsp_pkg::RSP_RUN, 4'h2);
      chk({setpoint_out, event_out, 8'h0}, 32'h03002200);
      st(rsp_pkg::RSP_START, 4'h0);
      chk({setpoint_out, event_out, 8'h0}, 32'h00505A00);
      $display("test run_hold done");
      cmd(8'h02);
      st(rsp_pkg::RSP_RUN, 4'h1);
      pv_goal <= 16'h010B;
      st(rsp_pkg::RSP_TOL_HOLD, 4'h1);
      apb(1'b0, 12'h018, 32'h0);
      e = r[15:0];
      repeat (300) @(posedge clk);
      apb(1'b0, 12'h018, 32'h0);
      chk(r, {16'h0, e});
      cmd(8'h08);
      st(rsp_pkg::RSP_TOL_HOLD, 4'h1);
      wait_alarm();
      chk({31'h0, alarm_out}, 32'h1);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, r[9]}, 32'h1);
      cmd(8'h20);
      repeat (2) @(posedge clk);
      apb(1'b0, 12'h010, 32'h0);
      chk({30'h0, alarm_out, r[9]}, 32'h0);
      wait_alarm();
      chk({31'h0, n >= 1000 && alarm_out === 1'b1}, 32'h1);
      cmd(8'h20);
      pv_goal <= 16'h0100;
      st(rsp_pkg::RSP_RUN, 4'h1);
      cmd(8'h10);
      st(rsp_pkg::RSP_START, 4'h0);
      chk({setpoint_out, event_out, 8'h0}, 32'h00505A00);
      cmd(8'h40);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, r[8]}, 32'h0);
      cmd(8'h01);
      apb(1'b0, 12'h010, 32'h0);
      chk({31'h0, r[8]}, 32'h1);
      $display("test tolerance_reset done");
      apb(1'b1, 12'h004, 32'h00015A01);
      apb(1'b1, 12'h108, 32'h030A0100);
      cmd(8'h80);
      cmd(8'h02);
      st(rsp_pkg::RSP_WAIT, 4'h1);
      repeat (300) @(posedge clk);
      apb(1'b0, 12'h018, 32'h0);
      chk(r, 32'h0);
      cmd(8'h08);
      st(rsp_pkg::RSP_WAIT, 4'h1);
      trig_goal <= 2'b01;
      repeat (4) @(posedge clk);
      trig_goal <= 2'b00;
      st(rsp_pkg::RSP_RUN, 4'h1);
      cmd(8'h10);
      cmd(8'h01);
      apb(1'b1, 12'h108, 32'h070A0100);
      cmd(8'h80);
      cmd(8'h02);
      trig_goal <= 2'b01;
      repeat (4) @(posedge clk);
      trig_goal <= 2'b00;
      st(rsp_pkg::RSP_WAIT, 4'h1);
      trig_goal <= 2'b10;
      st(rsp_pkg::RSP_RUN, 4'h1);
      trig_goal <= 2'b00;
      $display("test triggers done");
      pwr_pulse();
      st(rsp_pkg::RSP_START, 4'h0);
      apb(1'b1, 12'h004, 32'h00005A81);
      apb(1'b1, 12'h108, 32'h010A0100);
      cmd(8'h01);
      cmd(8'h02);
      st(rsp_pkg::RSP_RUN, 4'h1);
      repeat (150) @(posedge clk);
      apb(1'b0, 12'h018, 32'h0);
      e = r[15:0];
      pwr_pulse();
      st(rsp_pkg::RSP_RUN, 4'h1);
      apb(1'b0, 12'h018, 32'h0);
      chk({31'h0, r[15:0] >= e && e != 16'h0}, 32'h1);
      cmd(8'h10);
      apb(1'b1, 12'h108, 32'h01F60100);
      cmd(8'h02);
      pv_goal <= 16'h00F5;
      st(rsp_pkg::RSP_TOL_HOLD, 4'h1);
      pv_goal <= 16'h00F6;
      st(rsp_pkg::RSP_RUN, 4'h1);
      $display("test power_restore done");
      print_verdict();
   end
endmodule : tb_ramp_soak_profile_sequencer
